// *** pkg/ubfc_pkg.sv ***
// Purpose: Constants for the serial baud and framing control block.
// Assumes: 8-bit register port, one 250 MHz CPU clock.
// Notes: Offsets are byte addresses on the plain register port.
package ubfc_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_SCS = 8'h00;
   localparam logic [7:0] ADDR_PCR = 8'h01;
   localparam logic [7:0] ADDR_TMODE = 8'h02;
   localparam logic [7:0] ADDR_TCTL = 8'h03;
   localparam logic [7:0] ADDR_TLOW = 8'h04;
   localparam logic [7:0] ADDR_THIGH = 8'h05;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h06;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h07;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h08;
   // Control register fields
   localparam int SCS_MODE_HI = 7;
   localparam int SCS_RI = 0;
   localparam int SCS_TI = 1;
   localparam int SCS_RB8 = 2;
   // Power control fields
   localparam int PCR_BIT7_SEL = 6;
   localparam int PCR_DOUBLE = 7;
   // Timer fields
   localparam int TMODE_GATE = 7;
   localparam int TMODE_CNT = 6;
   localparam int TMODE_M_LO = 4;
   localparam int TCTL_RUN = 0;
   // Interrupt status bits
   localparam int IRQ_RX = 0;
   localparam int IRQ_TX = 1;
   localparam int IRQ_FE = 2;
   localparam int IRQ_TOVF = 3;
   localparam int IRQ_W = 4;
   // Reset values
   localparam logic [7:0] SCS_RST = 8'h00;
   localparam logic [7:0] PCR_RST = 8'h00;
   localparam logic [7:0] TMODE_RST = 8'h00;
   // Serial modes
   localparam logic [1:0] SMODE_SHIFT = 2'h0;
   localparam logic [1:0] SMODE_FIX9 = 2'h2;
   // Timer 1 running modes
   localparam logic [1:0] T1_MODE_13 = 2'h0;
   localparam logic [1:0] T1_MODE_16 = 2'h1;
   localparam logic [1:0] T1_MODE_RELOAD = 2'h2;
   // Timing: CPU clocks per machine cycle, oversampling factor
   localparam int MACH_DIV = 6;
   localparam logic [2:0] MACH_LAST = 3'(MACH_DIV - 1);
   localparam int OVS = 16;
   localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
endpackage

// *** pkg/ubfc_tmr_if.sv ***
// Purpose: Carrier between the register front end and timer 1.
// Assumes: Single clock domain.
// Notes: cnt is a one-cycle count enable.
`timescale 1ns/10ps
interface ubfc_tmr_if;
   logic [1:0] mode;
   logic cnt;
   logic wr_low;
   logic wr_high;
   logic [7:0] wdata;
   logic [7:0] low;
   logic [7:0] high;
   logic ovf;
   modport ctl (output mode, cnt, wr_low, wr_high, wdata,
      input low, high, ovf);
   modport tmr (input mode, cnt, wr_low, wr_high, wdata,
      output low, high, ovf);
endinterface

// *** rtl/ubfc_timer1.sv ***
// Purpose: Timer 1 counter used as the baud source.
// Assumes: cnt already qualified by run, gate and timer/counter choice.
// Notes: Mode 3 holds the count; ovf is a one-cycle pulse.
`timescale 1ns/10ps
module ubfc_timer1 import ubfc_pkg::*; (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Front end
   ubfc_tmr_if.tmr t_if
);
   logic [7:0] low;
   logic [7:0] high;
   logic ovf;
   logic [7:0] next_low;
   logic [7:0] next_high;
   logic next_ovf;

   wire [12:0] c13 = {high, low[4:0]} + 13'h0001;
   wire [15:0] c16 = {high, low} + 16'h0001;
   wire [7:0] c8 = low + 8'h01;
   wire wrap13 = &{high, low[4:0]};
   wire wrap16 = &{high, low};
   wire wrap8 = &low;

   always_comb begin
      next_low = low;
      next_high = high;
      next_ovf = 1'b0;
      if (t_if.cnt) begin
         case (t_if.mode)
            T1_MODE_13: begin
               next_low = {low[7:5], c13[4:0]};
               next_high = c13[12:5];
               next_ovf = wrap13;
            end
            T1_MODE_16: begin
               next_low = c16[7:0];
               next_high = c16[15:8];
               next_ovf = wrap16;
            end
            T1_MODE_RELOAD: begin
               // High byte is left untouched by reload
               next_low = wrap8 ? high : c8;
               next_ovf = wrap8;
            end
            default: begin
               next_ovf = 1'b0;
            end
         endcase
      end
      if (t_if.wr_low) next_low = t_if.wdata;
      if (t_if.wr_high) next_high = t_if.wdata;
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         low <= 8'h00;
         high <= 8'h00;
         ovf <= 1'b0;
      end else begin
         low <= next_low;
         high <= next_high;
         ovf <= next_ovf;
      end
   end

   assign t_if.low = low;
   assign t_if.high = high;
   assign t_if.ovf = ovf;

   a_reload_value: assert property (@(posedge ref_clk_in)
      disable iff (rst_in)
      t_if.mode == T1_MODE_RELOAD && t_if.cnt && wrap8
      && !t_if.wr_low && !t_if.wr_high
      |=> low == $past(high) && ovf && $stable(high))
      else $error("auto-reload did not reload low byte");
   a_stop_hold: assert property (@(posedge ref_clk_in)
      disable iff (rst_in)
      t_if.mode == 2'h3 && !t_if.wr_low && !t_if.wr_high
      |=> $stable(low) && $stable(high) && !ovf)
      else $error("timer moved in stopped mode");
   c_reload: cover property (@(posedge ref_clk_in)
      disable iff (rst_in)
      t_if.mode == T1_MODE_RELOAD && ovf);
endmodule

// *** rtl/ubfc_top.sv ***
// Purpose: Baud selection and control/status of the serial port.
// Assumes: Frame engine on the same clock reports events as pulses.
// Notes: Timer pins are asynchronous and synchronised here.
`timescale 1ns/10ps
module ubfc_top import ubfc_pkg::*; (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rd_data_out,
   // Frame engine events
   input wire logic rx_done_in,
   input wire logic rx_ninth_in,
   input wire logic rx_stop_bad_in,
   input wire logic tx_done_in,
   // Timer 1 pins
   input wire logic t1_count_pin_in,
   input wire logic t1_gate_pin_in,
   // Frame engine control
   output logic [1:0] mode_out,
   output logic multiproc_out,
   output logic rx_enable_out,
   output logic tx_ninth_bit_out,
   output logic rx_done_flag_out,
   output logic tx_done_flag_out,
   output logic sample_tick_out,
   output logic bit_tick_out,
   // Interrupt
   output logic irq_out
);
   ////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] scs;
   logic fe;
   logic [7:0] pcr;
   logic [7:0] tmode;
   logic run;
   logic [IRQ_W-1:0] status;
   logic [IRQ_W-1:0] irq_en;
   logic [2:0] mach_cnt;
   logic mach_tick;
   logic half;
   logic [3:0] ovs_cnt;
   logic [1:0] cpin_sync;
   logic [1:0] gpin_sync;
   logic cpin_prev;

   ubfc_tmr_if t_if ();

   ubfc_timer1 u_timer1 (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .t_if(t_if.tmr)
   );

   ////////////////////////////////////////////////////////////////////
   // Address decode
   wire wr_scs = wr_in && addr_in == ADDR_SCS;
   wire wr_pcr = wr_in && addr_in == ADDR_PCR;
   wire wr_tmode = wr_in && addr_in == ADDR_TMODE;
   wire wr_tctl = wr_in && addr_in == ADDR_TCTL;
   wire wr_clr = wr_in && addr_in == ADDR_IRQ_CLR;
   wire wr_en = wr_in && addr_in == ADDR_IRQ_EN;
   wire bit7_select = pcr[PCR_BIT7_SEL];
   wire baud_double = pcr[PCR_DOUBLE];
   wire [1:0] mode = {scs[SCS_MODE_HI], scs[SCS_MODE_HI-1]};

   ////////////////////////////////////////////////////////////////////
   // Control register update; hardware set wins over software write
   wire [IRQ_W-1:0] ev = {t_if.ovf, rx_stop_bad_in, tx_done_in,
      rx_done_in};
   logic [7:0] next_scs;
   logic next_fe;

   always_comb begin
      next_scs = scs;
      next_fe = fe;
      if (wr_scs) begin
         next_scs[6:0] = wr_data_in[6:0];
         // Bit 7 write reaches whichever bit is in view
         if (bit7_select) next_fe = wr_data_in[SCS_MODE_HI];
         else next_scs[SCS_MODE_HI] = wr_data_in[SCS_MODE_HI];
      end
      if (rx_done_in) begin
         next_scs[SCS_RI] = 1'b1;
         next_scs[SCS_RB8] = rx_ninth_in;
      end
      if (tx_done_in) next_scs[SCS_TI] = 1'b1;
      // Sticky until software writes it clear
      if (rx_stop_bad_in) next_fe = 1'b1;
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         scs <= SCS_RST;
         fe <= 1'b0;
      end else begin
         scs <= next_scs;
         fe <= next_fe;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Power control, timer mode and timer control
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pcr <= PCR_RST; // baud_double starts at 0
         tmode <= TMODE_RST;
         run <= 1'b0;
      end else begin
         if (wr_pcr) pcr <= wr_data_in;
         if (wr_tmode) tmode <= wr_data_in;
         if (wr_tctl) run <= wr_data_in[TCTL_RUN];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt status, clear and enable
   wire [IRQ_W-1:0] next_status =
      (status & ~(wr_clr ? wr_data_in[IRQ_W-1:0] : 4'h0)) | ev;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         status <= 4'h0;
         irq_en <= 4'h0;
         irq_out <= 1'b0;
      end else begin
         status <= next_status;
         if (wr_en) irq_en <= wr_data_in[IRQ_W-1:0];
         irq_out <= |(next_status & irq_en);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Machine cycle divider
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mach_cnt <= 3'h0;
         mach_tick <= 1'b0;
      end else begin
         mach_cnt <= (mach_cnt == MACH_LAST) ? 3'h0 : mach_cnt + 3'h1;
         mach_tick <= mach_cnt == MACH_LAST;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Timer 1 count enable; pins pass two flops first
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cpin_sync <= 2'h3;
         gpin_sync <= 2'h0;
         cpin_prev <= 1'b1;
      end else begin
         cpin_sync <= {cpin_sync[0], t1_count_pin_in};
         gpin_sync <= {gpin_sync[0], t1_gate_pin_in};
         if (mach_tick) cpin_prev <= cpin_sync[1];
      end
   end

   // Counter use sees a fall between two machine-cycle samples
   wire cpin_fall = mach_tick && cpin_prev && !cpin_sync[1];
   wire gate_ok = !tmode[TMODE_GATE] || gpin_sync[1];
   wire cnt_src = tmode[TMODE_CNT] ? cpin_fall : mach_tick;

   assign t_if.mode = tmode[TMODE_M_LO+1:TMODE_M_LO];
   assign t_if.cnt = run && gate_ok && cnt_src;
   assign t_if.wr_low = wr_in && addr_in == ADDR_TLOW;
   assign t_if.wr_high = wr_in && addr_in == ADDR_THIGH;
   assign t_if.wdata = wr_data_in;

   ////////////////////////////////////////////////////////////////////
   // Baud generation
   // Mode 2 feeds every clock, modes 1 and 3 feed timer overflows
   wire pre_src = (mode == SMODE_FIX9) ? 1'b1 : t_if.ovf;
   // Halving is skipped when doubled, giving /16 or /32
   wire pre_pass = pre_src && (baud_double || half);
   wire is_shift = mode == SMODE_SHIFT;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         half <= 1'b0;
         ovs_cnt <= 4'h0;
         sample_tick_out <= 1'b0;
         bit_tick_out <= 1'b0;
      end else begin
         if (pre_src) half <= ~half;
         if (pre_pass) ovs_cnt <= ovs_cnt + 4'h1;
         // Shift mode ignores timer and doubling
         sample_tick_out <= is_shift ? mach_tick : pre_pass;
         // One bit per 16 samples, so 192*count per bit, 96*count when doubled
         bit_tick_out <= is_shift ? mach_tick
            : (pre_pass && ovs_cnt == OVS_LAST);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read path; data stand one cycle only
   wire [7:0] scs_view = {bit7_select ? fe : scs[SCS_MODE_HI],
      scs[6:0]};
   logic [7:0] rd_mux;

   always_comb begin
      case (addr_in)
         ADDR_SCS: rd_mux = scs_view;
         ADDR_PCR: rd_mux = pcr;
         ADDR_TMODE: rd_mux = tmode;
         ADDR_TCTL: rd_mux = {7'h00, run};
         ADDR_TLOW: rd_mux = t_if.low;
         ADDR_THIGH: rd_mux = t_if.high;
         ADDR_IRQ_STAT: rd_mux = {4'h0, status};
         ADDR_IRQ_EN: rd_mux = {4'h0, irq_en};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) rd_data_out <= 8'h00;
      else rd_data_out <= rd_in ? rd_mux : 8'h00;
   end

   ////////////////////////////////////////////////////////////////////
   // Control outputs
   assign mode_out = mode;
   assign multiproc_out = scs[5];
   assign rx_enable_out = scs[4];
   assign tx_ninth_bit_out = scs[3];
   assign rx_done_flag_out = scs[SCS_RI];
   assign tx_done_flag_out = scs[SCS_TI];

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   a_done_flags: assert property (rx_done_in ##0 tx_done_in
      |=> rx_done_flag_out && tx_done_flag_out)
      else $error("done flags not set by events");
   a_bit7_view: assert property (rd_in && addr_in == ADDR_SCS
      |=> rd_data_out[7] == $past(bit7_select ? fe : scs[7]))
      else $error("bit 7 shows the wrong source");
   a_fe_set: assert property (rx_stop_bad_in |=> fe)
      else $error("framing error not set");
   a_fe_sticky: assert property (fe && !(wr_scs && bit7_select)
      |=> fe)
      else $error("framing error dropped without clear");
   a_shift_rate: assert property (mach_tick
      |=> !mach_tick [*5] ##1 mach_tick)
      else $error("machine cycle is not six clocks");
   a_shift_tick: assert property (is_shift && mach_tick
      |=> sample_tick_out && bit_tick_out)
      else $error("shift mode tick missing");
   // Prior cycle must be slow fixed mode too, or the tick came from another
   a_fix9_slow: assert property (mode == SMODE_FIX9 && !baud_double
      && $past(mode == SMODE_FIX9 && !baud_double)
      && !wr_pcr && !wr_scs && sample_tick_out
      |=> !sample_tick_out)
      else $error("fixed mode ticks too fast");
   a_fix9_fast: assert property (mode == SMODE_FIX9 && baud_double
      |=> sample_tick_out)
      else $error("doubled fixed mode misses a tick");
   a_ovf_tick: assert property (mode[0] && t_if.ovf && baud_double
      |=> sample_tick_out)
      else $error("overflow did not give a sample tick");
   a_counter_fall: assert property (t_if.cnt |-> mach_tick)
      else $error("count outside machine cycle");
   a_irq_level: assert property (status[IRQ_FE] && irq_en[IRQ_FE]
      && !wr_clr |=> irq_out)
      else $error("enabled status did not raise interrupt");

   c_shift_bit: cover property (is_shift && bit_tick_out);
   c_fe_seen: cover property (fe && bit7_select && rd_in);
   c_var_bit: cover property (mode[0] && bit_tick_out);
endmodule

// *** tb/ubfc_far_end.sv ***
// Purpose: Far-side model: frame engine events and timer count pin.
// Assumes: Same clock as the block; events are one-cycle pulses.
// Notes: The ninth-bit line idles at the inverse of its last value.
`timescale 1ns/10ps
module ubfc_far_end (
   // Clock
   input wire logic ref_clk_in,
   // Event pulses
   output logic rx_done_out,
   output logic rx_ninth_out,
   output logic rx_stop_bad_out,
   output logic tx_done_out,
   // Timer count pin
   output logic t1_pin_out
);
   logic run;
   logic [7:0] cnt;
   initial begin
      rx_done_out = 1'b0;
      rx_ninth_out = 1'b0;
      rx_stop_bad_out = 1'b0;
      tx_done_out = 1'b0;
      t1_pin_out = 1'b1;
      run = 1'b0;
      cnt = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////
   // Pin period of 24 clocks, a whole number of machine cycles
   always @(posedge ref_clk_in) begin
      if (run) begin
         if (cnt == 8'h0B) begin
            cnt <= 8'h00;
            t1_pin_out <= ~t1_pin_out;
         end else begin
            cnt <= cnt + 8'h01;
         end
      end
   end
   task automatic pin_run(input logic on);
      @(posedge ref_clk_in);
      run <= on;
   endtask
   // Received character; a bad stop bit comes with it
   task automatic rx_char(input logic ninth, input logic bad);
      @(posedge ref_clk_in);
      rx_done_out <= 1'b1;
      rx_ninth_out <= ninth;
      rx_stop_bad_out <= bad;
      @(posedge ref_clk_in);
      rx_done_out <= 1'b0;
      rx_stop_bad_out <= 1'b0;
      rx_ninth_out <= ~ninth;
   endtask
   task automatic tx_char();
      @(posedge ref_clk_in);
      tx_done_out <= 1'b1;
      @(posedge ref_clk_in);
      tx_done_out <= 1'b0;
   endtask
endmodule

// *** tb/ubfc_top_bench.sv ***
// Purpose: Self-checking bench for baud selection and control/status.
// Assumes: Register port answers reads one cycle after the strobe.
// Notes: Tick periods are measured after two ticks to skip prescaler skew.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module ubfc_top_bench import ubfc_pkg::*;;
   logic ref_clk_in, rst_in, wr_in, rd_in, gate;
   logic [7:0] addr_in, wr_data_in, rd_data_out;
   logic rx_done, rx_ninth, rx_bad, tx_done, t1_pin;
   logic [1:0] mode_out;
   logic tx_ninth_bit_out, rx_done_flag_out, tx_done_flag_out;
   logic bit_tick_out, irq_out, sample_tick_out, multiproc_out;
   logic rx_enable_out;
   int n_mismatch = 0;
   int checked = 0;
   ubfc_far_end u_far (.ref_clk_in(ref_clk_in), .rx_done_out(rx_done),
      .rx_ninth_out(rx_ninth), .rx_stop_bad_out(rx_bad),
      .tx_done_out(tx_done), .t1_pin_out(t1_pin));
   ubfc_top dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
      .rd_in(rd_in), .rd_data_out(rd_data_out), .rx_done_in(rx_done),
      .rx_ninth_in(rx_ninth), .rx_stop_bad_in(rx_bad),
      .tx_done_in(tx_done), .t1_count_pin_in(t1_pin),
      .t1_gate_pin_in(gate), .mode_out(mode_out),
      .multiproc_out(multiproc_out), .rx_enable_out(rx_enable_out),
      .tx_ninth_bit_out(tx_ninth_bit_out),
      .rx_done_flag_out(rx_done_flag_out),
      .tx_done_flag_out(tx_done_flag_out),
      .sample_tick_out(sample_tick_out),
      .bit_tick_out(bit_tick_out), .irq_out(irq_out));
   initial begin
      ref_clk_in = 1'b0;
      forever #2 ref_clk_in = ~ref_clk_in;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wr_data_in <= d;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1 `CHK(rd_data_out, e)
   endtask
   // Third gap between bit ticks; earlier ones may be partial
   task automatic gap(input int e);
      int n;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         do begin
            @(posedge ref_clk_in);
            #1 n++;
         end while (bit_tick_out !== 1'b1 && n < 2000);
      end
      `CHK(n, e)
   endtask
   task automatic give_verdict();
      if (n_mismatch == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000 n_mismatch++;
      give_verdict();
   end
   initial begin
      rst_in = 1'b1;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 8'h00;
      wr_data_in = 8'h00;
      gate = 1'b1;
      repeat (8) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rd_chk(ADDR_SCS, SCS_RST);
      rd_chk(ADDR_PCR, PCR_RST);
      gap(6);
      `CHK(sample_tick_out, 1'b1)
      wr(ADDR_SCS, 8'h80);
      gap(32);
      wr(ADDR_PCR, 8'h80);
      gap(16);
      `CHK(sample_tick_out, 1'b1)
      wr(ADDR_THIGH, 8'hFE);
      wr(ADDR_TLOW, 8'hFE);
      wr(ADDR_TMODE, 8'h20);
      wr(ADDR_TCTL, 8'h01);
      wr(ADDR_SCS, 8'h40);
      gap(96 * 2);
      wr(ADDR_PCR, 8'h00);
      wr(ADDR_SCS, 8'hC0);
      gap(192 * 2);
      wr(ADDR_SCS, 8'h00);
      gap(6);
      rd_chk(ADDR_IRQ_STAT, 8'h08);
      // Counter use: one count per pin period of 24 clocks
      wr(ADDR_THIGH, 8'hFF);
      wr(ADDR_TMODE, 8'h60);
      u_far.pin_run(1'b1);
      wr(ADDR_SCS, 8'h40);
      gap(16 * 2 * 24);
      u_far.pin_run(1'b0);
      wr(ADDR_TCTL, 8'h00);
      wr(ADDR_SCS, 8'h00);
      // 16-bit use held by the gate pin, then 13-bit use
      wr(ADDR_IRQ_CLR, 8'h0F);
      gate <= 1'b0;
      wr(ADDR_TMODE, 8'h90);
      wr(ADDR_THIGH, 8'hFF);
      wr(ADDR_TLOW, 8'hFF);
      wr(ADDR_TCTL, 8'h01);
      repeat (12) @(posedge ref_clk_in);
      rd_chk(ADDR_THIGH, 8'hFF);
      gate <= 1'b1;
      repeat (12) @(posedge ref_clk_in);
      wr(ADDR_TCTL, 8'h00);
      rd_chk(ADDR_THIGH, 8'h00);
      rd_chk(ADDR_IRQ_STAT, 8'h08);
      wr(ADDR_IRQ_CLR, 8'h0F);
      wr(ADDR_TMODE, 8'h00);
      wr(ADDR_THIGH, 8'hFF);
      wr(ADDR_TLOW, 8'h1F);
      wr(ADDR_TCTL, 8'h01);
      repeat (12) @(posedge ref_clk_in);
      wr(ADDR_TCTL, 8'h00);
      rd_chk(ADDR_THIGH, 8'h00);
      rd_chk(ADDR_IRQ_STAT, 8'h08);
      // Stopped use holds the count
      wr(ADDR_TMODE, 8'h30);
      wr(ADDR_TLOW, 8'h55);
      wr(ADDR_TCTL, 8'h01);
      repeat (12) @(posedge ref_clk_in);
      rd_chk(ADDR_TLOW, 8'h55);
      wr(ADDR_TCTL, 8'h00);
      wr(ADDR_IRQ_CLR, 8'h0F);
      // Only the framing error interrupt is enabled; a bad stop bit raises it
      wr(ADDR_IRQ_EN, 8'h04);
      u_far.rx_char(1'b1, 1'b1);
      #1 `CHK(irq_out, 1'b1)
      `CHK(rx_done_flag_out, 1'b1)
      rd_chk(ADDR_SCS, 8'h05);
      wr(ADDR_PCR, 8'h40);
      rd_chk(ADDR_SCS, 8'h85);
      u_far.rx_char(1'b0, 1'b0);
      rd_chk(ADDR_SCS, 8'h81);
      u_far.tx_char();
      rd_chk(ADDR_SCS, 8'h83);
      `CHK(tx_done_flag_out, 1'b1)
      wr(ADDR_SCS, 8'h00);
      rd_chk(ADDR_SCS, 8'h00);
      // Receive and transmit done in the same cycle
      fork
         u_far.rx_char(1'b0, 1'b0);
         u_far.tx_char();
      join
      rd_chk(ADDR_SCS, 8'h03);
      rd_chk(ADDR_IRQ_STAT, 8'h07);
      wr(ADDR_IRQ_CLR, 8'h04);
      #1 `CHK(irq_out, 1'b0)
      // Status is read-only; stray address reads as zero
      wr(ADDR_IRQ_STAT, 8'hFF);
      rd_chk(ADDR_IRQ_STAT, 8'h03);
      rd_chk(8'h20, 8'h00);
      wr(ADDR_PCR, 8'h00);
      wr(ADDR_SCS, 8'hC8);
      rd_chk(ADDR_SCS, 8'hC8);
      `CHK(mode_out, 2'b11)
      `CHK(tx_ninth_bit_out, 1'b1)
      wr(ADDR_SCS, 8'h30);
      #1 `CHK(multiproc_out, 1'b1)
      `CHK(rx_enable_out, 1'b1)
      `CHK(mode_out, 2'b00)
      give_verdict();
   end
endmodule
